// ---- logic/cio_ports.sv ----
// Four configurable I/O ports: output mux, readback, input cells and enables
`timescale 1ns/100ps
module cio_ports import cio_pkg::*; #(
  parameter int W = CIO_WIDE_W,
  parameter int DW = CIO_NARROW_W,
  parameter cio_bus_e BUS_TYPE = CIO_BUS_MUX,
  parameter logic [W-1:0] DATA_PORT_A = '0,
  parameter logic [3*W-1:0] LOGIC_OUT = '0,
  parameter logic [DW-1:0] LOGIC_OUT_D = '0,
  parameter logic [3*W-1:0] CS_OUT_D = '0,
  parameter logic [3*W-1:0] GRP_HIGH_SEL = '0,
  parameter logic [5:0] ICELL_MODE = '0,
  parameter logic [2:0] ICELL_TERM_CLK = '0,
  parameter logic TEST_CFG = 1'b0
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Async reset, high
  input wire logic reg_wr, // Host write strobe
  input wire logic reg_rd, // Host read strobe
  input wire logic [1:0] reg_port, // Port select
  input wire logic [2:0] reg_kind, // Register select
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data
  output logic reg_rdata_oe, // Read data drive, low drives
  input wire logic [15:0] host_addr, // Latched host address
  input wire logic address_latch_strobe, // Address strobe
  input wire logic [7:0] host_data_in, // Host data bus in
  output logic [7:0] host_data_out, // Host data from port A
  input wire logic host_rd, // Host read strobe for peripheral buffer
  input wire logic periph_select_a, // Peripheral select term
  input wire logic periph_select_b, // Peripheral select term
  input wire logic [3*W-1:0] cell_group_low, // Cell outputs, ports A/B
  input wire logic [3*W-1:0] cell_group_high, // Cell outputs, ports B/C
  input wire logic [2:0] ext_chip_selects, // Chip selects for port D
  input wire logic [3*W+DW-1:0] pt_oe, // Product-term enables
  input wire logic [2:0] icell_term, // Input cell product-term clocks
  input wire logic test_port_select, // Test select from logic
  input wire logic test_enable, // Test enable control
  output logic test_port_active, // Port C given to test port
  input wire logic [3*W+DW-1:0] pin_in, // Pin levels
  output logic [3*W+DW-1:0] pin_out, // Pin drive
  output logic [3*W+DW-1:0] pin_oe, // Pin enable, low drives
  output logic [3*W-1:0] input_cell_out // Input cells to logic bus
);
  localparam int NP = 3 * W + DW;

  typedef struct packed {
    logic [NP-1:0] dout;
    logic [NP-1:0] dir;
    logic [2*W-1:0] ctrl;
    logic [7:0] mem_mode;
    logic [3*W-1:0] icell;
    logic [2:0] term_q;
    logic [7:0] rdata;
  } cio_state_s;

  cio_state_s st_reg, st_next;

  function automatic logic [7:0] cio_byte(input logic [NP-1:0] v, input logic [1:0] p);
    cio_byte = (p == CIO_PORT_D) ? {5'h00, v[3*W +: DW]} : v[p*W +: W];
  endfunction : cio_byte

  logic [NP-1:0] mux_out, drv_en, adr_out, adr_ok;
  logic pio_on, dbus_on;
  logic [3*W-1:0] cell_out;

  always_comb begin
    adr_out = '0;
    case (BUS_TYPE)
      CIO_BUS_BURST: begin
        adr_out[7:4] = host_addr[7:4];
        adr_out[11:8] = host_addr[11:8];
      end
      CIO_BUS_PAGE: adr_out[15:8] = host_addr[15:8];
      CIO_BUS_NONMUX: adr_out[15:8] = host_addr[7:0];
      default: begin
        adr_out[7:0] = host_addr[7:0];
        adr_out[15:8] = host_addr[7:0];
      end
    endcase
  end

  assign pio_on = st_reg.mem_mode[CIO_PIO_BIT];
  assign dbus_on = (BUS_TYPE == CIO_BUS_NONMUX) && (DATA_PORT_A != '0);
  assign test_port_active = test_port_select | TEST_CFG | test_enable;

  always_comb begin
    for (int i = 0; i < 3 * W; i++) begin
      // Group low on A/B, group high on B/C
      cell_out[i] = (i >= 2 * W || (i >= W && GRP_HIGH_SEL[i])) ? cell_group_high[i] : cell_group_low[i];
    end
  end

  always_comb begin
    mux_out = st_reg.dout;
    drv_en = pt_oe | st_reg.dir;
    adr_ok = '0;
    for (int i = 0; i < NP; i++) begin
      if (i < 3 * W && CS_OUT_D[i] == 1'b0 && LOGIC_OUT[i]) begin
        mux_out[i] = cell_out[i];
      end
      if (i < 2 * W && st_reg.ctrl[i]) begin
        adr_ok[i] = 1'b1;
        mux_out[i] = adr_out[i];
        drv_en[i] = pt_oe[i] | st_reg.dir[i];
      end
      if (i >= 3 * W && i < 3 * W + 3 && LOGIC_OUT_D[i-3*W]) begin
        mux_out[i] = ext_chip_selects[i-3*W];
      end
    end
    if (adr_ok == '0 && pt_oe == '0) begin
      drv_en = st_reg.dir;
    end
    if (BUS_TYPE == CIO_BUS_NONMUX) begin
      drv_en[W-1:0] &= ~st_reg.ctrl[W-1:0];
    end
    if (test_port_active) begin
      drv_en[3*W-1:2*W] = '0;
    end
    if (dbus_on || pio_on) begin
      mux_out[W-1:0] = host_data_in;
      drv_en[W-1:0] = {W{(periph_select_a | periph_select_b) & ~host_rd & (pio_on | dbus_on)}};
    end
  end

  always_comb begin
    pin_out = mux_out;
    pin_oe = ~drv_en;
    host_data_out = pin_in[W-1:0];
    input_cell_out = st_reg.icell;
    reg_rdata = st_reg.rdata;
    reg_rdata_oe = ~reg_rd;
  end

  always_comb begin
    st_next = st_reg;
    st_next.term_q = icell_term;
    for (int p = 0; p < 3; p++) begin
      for (int b = 0; b < W; b++) begin
        logic clk_ev;
        clk_ev = ICELL_TERM_CLK[p] ? (icell_term[p] & ~st_reg.term_q[p]) : address_latch_strobe;
        case (cio_icell_e'(ICELL_MODE[2*p +: 2]))
          CIO_IC_LATCH: if (clk_ev) st_next.icell[p*W+b] = pin_in[p*W+b];
          CIO_IC_REG: if (clk_ev) st_next.icell[p*W+b] = pin_in[p*W+b];
          default: st_next.icell[p*W+b] = pin_in[p*W+b];
        endcase
      end
    end
    if (reg_wr) begin
      case (cio_reg_e'(reg_kind))
        CIO_R_DATA_OUT: begin
          if (reg_port == CIO_PORT_D) st_next.dout[3*W +: DW] = reg_wdata[DW-1:0];
          else st_next.dout[reg_port*W +: W] = reg_wdata;
        end
        CIO_R_DIR: begin
          if (reg_port == CIO_PORT_D) st_next.dir[3*W +: DW] = reg_wdata[DW-1:0];
          else st_next.dir[reg_port*W +: W] = reg_wdata;
        end
        CIO_R_CTRL: begin
          if (reg_port == CIO_PORT_A || reg_port == CIO_PORT_B) st_next.ctrl[reg_port*W +: W] = reg_wdata;
        end
        CIO_R_MEM_MODE: st_next.mem_mode = reg_wdata;
        default: st_next.mem_mode = st_reg.mem_mode;
      endcase
    end
    if (reg_rd) begin
      case (cio_reg_e'(reg_kind))
        CIO_R_DATA_IN: st_next.rdata = cio_byte(pin_in, reg_port);
        CIO_R_DATA_OUT: st_next.rdata = cio_byte(st_reg.dout, reg_port);
        CIO_R_DIR: st_next.rdata = cio_byte(st_reg.dir, reg_port);
        CIO_R_CTRL: st_next.rdata = (reg_port[1] == 1'b0) ? st_reg.ctrl[reg_port[0]*W +: W] : 8'h00;
        CIO_R_CELL_OUT: st_next.rdata = (reg_port == CIO_PORT_D) ? 8'h00 : cell_out[reg_port*W +: W];
        CIO_R_CELL_IN: st_next.rdata = (reg_port == CIO_PORT_D) ? 8'h00 : st_reg.icell[reg_port*W +: W];
        CIO_R_MEM_MODE: st_next.rdata = st_reg.mem_mode;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : cio_ports

// ---- pkg/cio_pkg.sv ----
// Package of constants and types for the configurable I/O port block
package cio_pkg;
  localparam int CIO_WIDE_W = 8;
  localparam int CIO_NARROW_W = 3;
  localparam logic [7:0] CIO_CFG_RST = 8'h00;
  localparam int CIO_PIO_BIT = 7;
  localparam logic [3:0] CIO_NPORT = 4'h4;

  // Host register select codes (port number in reg_port)
  localparam logic [1:0] CIO_PORT_A = 2'h0;
  localparam logic [1:0] CIO_PORT_B = 2'h1;
  localparam logic [1:0] CIO_PORT_C = 2'h2;
  localparam logic [1:0] CIO_PORT_D = 2'h3;

  // Register kinds within the I/O register space
  typedef enum logic [2:0] {
    CIO_R_DATA_IN = 3'b000,
    CIO_R_DATA_OUT = 3'b001,
    CIO_R_DIR = 3'b010,
    CIO_R_CTRL = 3'b011,
    CIO_R_CELL_OUT = 3'b100,
    CIO_R_CELL_IN = 3'b101,
    CIO_R_MEM_MODE = 3'b110
  } cio_reg_e;

  // Host bus type, fixed at programming
  typedef enum logic [1:0] {
    CIO_BUS_MUX = 2'b00,
    CIO_BUS_BURST = 2'b01,
    CIO_BUS_PAGE = 2'b10,
    CIO_BUS_NONMUX = 2'b11
  } cio_bus_e;

  // Input cell mode, fixed at programming
  typedef enum logic [1:0] {
    CIO_IC_DIRECT = 2'b00,
    CIO_IC_LATCH = 2'b01,
    CIO_IC_REG = 2'b10
  } cio_icell_e;
endpackage : cio_pkg

// ---- testbench/cio_ports_sva.sv ----
// Assertions on the port block's register and pin ports
`timescale 1ns/100ps
module cio_ports_sva import cio_pkg::*; (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [1:0] reg_port, // Port
  input wire logic [2:0] reg_kind, // Kind
  input wire logic [7:0] reg_wdata, // Wdata
  input wire logic [7:0] reg_rdata, // Rdata
  input wire logic reg_rdata_oe, // Rdata drive
  input wire logic [26:0] pt_oe, // Term enables
  input wire logic test_port_active, // Test active
  input wire logic [26:0] pin_in, // Pins in
  input wire logic [26:0] pin_out, // Pins out
  input wire logic [26:0] pin_oe // Pins enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence wr_dir_c;
    reg_wr && reg_port == CIO_PORT_C && reg_kind == CIO_R_DIR;
  endsequence
  sequence c_free;
    pt_oe[23:16] == 8'h00 && !test_port_active;
  endsequence
  term_oe_or_a: assert property ((pt_oe[15:8] & pin_oe[15:8]) == 8'h00) else $error("term enable not driving");
  rd_drive_a: assert property (reg_rdata_oe == !reg_rd) else $error("read drive wrong");
  test_off_a: assert property (test_port_active |-> pin_oe[23:16] == 8'hff) else $error("test port drives");
  dir_sets_oe_a: assert property (wr_dir_c ##1 c_free |-> pin_oe[23:16] == ~$past(reg_wdata))
    else $error("direction not applied");
  rd_pin_d_a: assert property (reg_rd && reg_port == CIO_PORT_D && reg_kind == CIO_R_DATA_IN
    |=> reg_rdata == {5'h00, $past(pin_in[26:24])}) else $error("data in wrong");
  unmapped_rd_a: assert property (reg_rd && reg_kind == 3'h7 |=> reg_rdata == 8'h00) else $error("unmapped read");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  dout_d_a: assert property (reg_wr && reg_port == CIO_PORT_D && reg_kind == CIO_R_DATA_OUT
    |=> pin_out[26:24] == $past(reg_wdata[2:0])) else $error("data out not on pins");
endmodule : cio_ports_sva
bind cio_ports cio_ports_sva chk_u (.*);

// ---- testbench/cio_pin_model.sv ----
// Far-side pin model: resolves every pin from both drivers
`timescale 1ns/100ps
module cio_pin_model (
  input wire logic ref_clk, // Clock
  input wire logic [26:0] pin_out, // Block drive
  input wire logic [26:0] pin_oe, // Block enable, low drives
  input wire logic [26:0] ext_en, // Far side drives
  input wire logic [26:0] ext_val, // Far side level
  output logic [26:0] pin_in // Resolved level
);
  logic [26:0] last_reg = 27'h0;
  // Floating pins flip each cycle so a stale value never passes
  always_comb pin_in = (~pin_oe & pin_out) | (pin_oe & ext_en & ext_val) | (pin_oe & ~ext_en & ~last_reg);
  always @(posedge ref_clk) last_reg <= pin_in;
endmodule : cio_pin_model

// ---- testbench/cio_ports_tb_top.sv ----
// Self-checking bench for the port block
`timescale 1ns/100ps
module cio_ports_tb_top import cio_pkg::*; ;
  logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, host_rd = 1'b0, test_port_select = 1'b0;
  logic test_enable = 1'b0, periph_select_a = 1'b0, periph_select_b = 1'b0, address_latch_strobe = 1'b0;
  logic [1:0] reg_port = 2'h0;
  logic [2:0] reg_kind = 3'h0, ext_chip_selects = 3'h0, icell_term = 3'h0;
  logic [7:0] reg_wdata = 8'h00, host_data_in = 8'h00, reg_rdata, host_data_out;
  logic [15:0] host_addr = 16'h0000;
  logic [23:0] cell_group_low = 24'h0, cell_group_high = 24'h0, input_cell_out;
  logic [26:0] pt_oe = 27'h0, ext_en = 27'h0, ext_val = 27'h0, pin_in, pin_out, pin_oe;
  logic reg_rdata_oe, test_port_active;
  int fail_count = 0, samples_checked = 0;
  cio_ports #(.ICELL_MODE(6'h15)) dut_u (.*);
  cio_pin_model pins_u (.*);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic chk(input logic [26:0] got, input logic [26:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [1:0] p, input logic [2:0] k, input logic [7:0] d);
    @(posedge ref_clk);
    reg_port <= p;
    reg_kind <= k;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    settle();
  endtask : acc
  task automatic t_reset();
    for (int p = 0; p < 4; p++) begin
      acc(1'b0, p[1:0], CIO_R_DIR, 8'h00);
      chk(reg_rdata, 8'h00);
    end
    chk(pin_oe, 27'h7ffffff);
    $display("reset test done");
  endtask : t_reset
  task automatic t_host();
    @(posedge ref_clk);
    ext_en[23:16] <= 8'hf0;
    ext_val[23:16] <= 8'h60;
    acc(1'b1, CIO_PORT_C, CIO_R_DIR, 8'h0f);
    acc(1'b1, CIO_PORT_C, CIO_R_DATA_OUT, 8'ha5);
    chk({pin_oe[23:16], pin_out[19:16]}, 12'hf05);
    acc(1'b0, CIO_PORT_C, CIO_R_DATA_IN, 8'h00);
    chk(reg_rdata, 8'h65);
    acc(1'b0, CIO_PORT_C, CIO_R_DATA_OUT, 8'h00);
    chk(reg_rdata, 8'ha5);
    acc(1'b1, CIO_PORT_D, CIO_R_DIR, 8'hf9);
    acc(1'b0, CIO_PORT_D, CIO_R_DIR, 8'h00);
    chk(reg_rdata, 8'h01);
    acc(1'b1, CIO_PORT_D, CIO_R_DATA_OUT, 8'h05);
    chk(pin_out[26:24], 3'h5);
    @(posedge ref_clk);
    pt_oe[26:24] <= 3'h4;
    settle();
    chk(pin_oe[26:24], 3'h2);
    acc(1'b0, CIO_PORT_D, CIO_R_DATA_IN, 8'h00);
    chk(reg_rdata & 8'h05, 8'h05);
    pt_oe <= 27'h0;
    $display("host io test done");
  endtask : t_host
  task automatic t_addr();
    @(posedge ref_clk);
    host_addr <= 16'h5a3c;
    acc(1'b1, CIO_PORT_B, CIO_R_DIR, 8'hff);
    acc(1'b1, CIO_PORT_B, CIO_R_DATA_OUT, 8'h11);
    acc(1'b1, CIO_PORT_B, CIO_R_CTRL, 8'hff);
    chk({pin_oe[15:8], pin_out[15:8]}, 16'h003c);
    acc(1'b1, CIO_PORT_B, CIO_R_CTRL, 8'h00);
    chk(pin_out[15:8], 8'h11);
    acc(1'b1, CIO_PORT_C, CIO_R_CTRL, 8'hff);
    acc(1'b0, CIO_PORT_C, CIO_R_CTRL, 8'h00);
    chk(reg_rdata, 8'h00);
    acc(1'b0, CIO_PORT_B, CIO_R_DIR, 8'h00);
    chk(reg_rdata, 8'hff);
    acc(1'b0, CIO_PORT_A, 3'h7, 8'h00);
    chk(reg_rdata, 8'h00);
    @(posedge ref_clk);
    test_enable <= 1'b1;
    settle();
    chk({test_port_active, pin_oe[23:16]}, 9'h1ff);
    @(posedge ref_clk);
    test_enable <= 1'b0;
    test_port_select <= 1'b1;
    settle();
    chk(test_port_active, 1'b1);
    @(posedge ref_clk);
    test_port_select <= 1'b0;
    settle();
    chk({test_port_active, pin_oe[23:16]}, 9'h0f0);
    $display("address and test port done");
  endtask : t_addr
  task automatic t_periph();
    acc(1'b1, CIO_PORT_A, CIO_R_MEM_MODE, 8'h80);
    @(posedge ref_clk);
    host_data_in <= 8'hc3;
    periph_select_a <= 1'b1;
    settle();
    chk({pin_oe[7:0], pin_out[7:0]}, 16'h00c3);
    @(posedge ref_clk);
    periph_select_a <= 1'b0;
    periph_select_b <= 1'b1;
    settle();
    chk(pin_oe[7:0], 8'h00);
    @(posedge ref_clk);
    host_rd <= 1'b1;
    settle();
    chk(pin_oe[7:0], 8'hff);
    @(posedge ref_clk);
    host_rd <= 1'b0;
    periph_select_b <= 1'b0;
    ext_en[7:0] <= 8'hff;
    ext_val[7:0] <= 8'h96;
    address_latch_strobe <= 1'b1;
    @(posedge ref_clk);
    address_latch_strobe <= 1'b0;
    ext_val[7:0] <= 8'h21;
    settle();
    chk({pin_oe[7:0], input_cell_out[7:0], host_data_out}, 24'hff9621);
    acc(1'b0, CIO_PORT_A, CIO_R_CELL_IN, 8'h00);
    chk(reg_rdata, 8'h96);
    $display("peripheral and input cell done");
  endtask : t_periph
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_host();
    t_addr();
    t_periph();
    final_report();
  end
endmodule : cio_ports_tb_top
